/* File: hw/usb_port_pkg.sv */
// constants and types for the root port status/control pair
//
// Overview of operation
// - after a hardware reset a port shows no device, disabled, line status 00.
// - suspend and enable bits encode disabled, enabled or suspended.
// - a suspended port blocks downstream traffic except reset signaling.
// - suspend waits for the running transaction; bit shows actual state.
// - with outbound babble a start-of-frame may go out before suspending.
// - over-current flag sets on inactive-to-active input; write one clears.
// - over-current active bit follows the active-low input live.
// - port reset bit keeps the port disabled and drives reset signaling.
// - slow device flag shows low speed attached; writes do nothing.
// - bit 7 reads one, reset value 0x0080, bits 15:13 read-only.
// - software writing one to the wake bit of a suspended port drives K-state resume.
// - suspended port sets wake bit after K held 32 microseconds.
// - detected resume reflects K while wake bit and suspend state hold.
// - clearing wake bit sends low-speed EOP; bit reads one until done.
// - each function owns two ports, numbered twice the function number.
// - first port decodes at offset 10h, second at offset 12h.
// - enable set by software only, cleared by faults on real change.
package usb_port_pkg;

    // ***************************************************
    // register map
    // ***************************************************
    localparam logic [7:0] PORT_A_OFS = 8'h10;
    localparam logic [7:0] PORT_B_OFS = 8'h12;
    localparam logic [15:0] PORT_STATUS_CONTROL_RESET = 16'h0080;
    localparam int BIT_SUSP = 12;
    localparam int BIT_OC_FLAG = 11;
    localparam int BIT_OC_ACT = 10;
    localparam int BIT_PRST = 9;
    localparam int BIT_SLOW = 8;
    localparam int BIT_RSV_ONE = 7;
    localparam int BIT_WAKE = 6;
    localparam int BIT_LINE_DM = 5;
    localparam int BIT_LINE_DP = 4;
    localparam int BIT_EN = 2;
    localparam int BIT_CONN = 0;

    // ***************************************************
    // timing
    // ***************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESUME_DET_US = 32;
    localparam int RESUME_DET_CYC = (RESUME_DET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EOP_SE0_NS = 1334;
    localparam int EOP_J_NS = 667;
    localparam int EOP_SE0_CYC = (EOP_SE0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EOP_J_CYC = (EOP_J_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;

    typedef enum logic [2:0] {
        EOP_IDLE = 3'b001,
        EOP_SE0 = 3'b010,
        EOP_J = 3'b100
    } eop_state_t;

endpackage

/* File: hw/usb_root_port_status_control.sv */
// status and control logic for one pair of root hub ports
`timescale 1ns/1ps
module usb_root_port_status_control
    import usb_port_pkg::*;
#(
    parameter int NPORTS = 2,
    parameter int FUNC_NUM = 0
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [1:0] io_be_i,
    input wire logic [15:0] io_wdata_i,
    output logic [15:0] io_rdata_o,
    input wire logic [NPORTS-1:0] oc_n_i,
    input wire logic [NPORTS-1:0] line_dp_i,
    input wire logic [NPORTS-1:0] line_dm_i,
    input wire logic [NPORTS-1:0] dev_present_i,
    input wire logic [NPORTS-1:0] xact_busy_i,
    input wire logic [NPORTS-1:0] babble_i,
    input wire logic [NPORTS-1:0] sof_done_i,
    output logic [NPORTS-1:0] sof_req_o,
    output logic [NPORTS-1:0] port_en_o,
    output logic [NPORTS-1:0] traffic_block_o,
    output logic [NPORTS-1:0] drive_se0_o,
    output logic [NPORTS-1:0] drive_k_o,
    output logic [NPORTS-1:0] drive_j_o,
    output logic [2:0] first_port_o
);

    // ***************************************************
    // address decode
    // ***************************************************
    function automatic logic port_hit(input logic [7:0] addr, input int idx);
        port_hit = (idx == 0) ? (addr == PORT_A_OFS) : (addr == PORT_B_OFS);
    endfunction

    // ***************************************************
    // physical port numbering of this function
    // ***************************************************
    assign first_port_o = 3'(FUNC_NUM * 2);

    logic [15:0] reg_val [NPORTS];

    // ***************************************************
    // per-port logic
    // ***************************************************
    genvar p;
    generate
        for (p = 0; p < NPORTS; p++) begin : g_port
            logic [3:0] sync1_q;
            logic [3:0] sync2_q;
            logic oc_prev_q;
            logic oc_act;
            logic dp_s;
            logic dm_s;
            logic pres_s;
            logic conn_q;
            logic wr_hit;
            logic en_q;
            logic susp_q;
            logic susp_pend_q;
            logic sof_wait_q;
            logic oc_flag_q;
            logic prst_q;
            logic wake_q;
            logic slow_q;
            logic k_line;
            logic [CNT_W-1:0] kcnt_q;
            logic [CNT_W-1:0] eop_cnt_q;
            eop_state_t eop_q;
            logic eop_busy;
            logic wake_set_hw;
            logic oc_rise;
            logic suspended;

            // ****************
            // two-stage synchroniser for pins
            // ****************
            // oc stage resets to the pin's idle high, so no false edge follows reset
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sync1_q <= 4'h8;
                    sync2_q <= 4'h8;
                end else begin
                    sync1_q <= {oc_n_i[p], line_dp_i[p], line_dm_i[p], dev_present_i[p]};
                    sync2_q <= sync1_q;
                end
            end

            assign pres_s = sync2_q[0];
            assign dm_s = sync2_q[1];
            assign dp_s = sync2_q[2];
            assign oc_act = ~sync2_q[3];
            assign oc_rise = oc_act && !oc_prev_q;
            assign suspended = susp_q && en_q;
            // only whole-word writes are taken
            assign wr_hit = io_wr_i && (io_be_i == 2'b11) && port_hit(io_addr_i, p);
            assign eop_busy = (eop_q != EOP_IDLE);

            // ****************
            // connect tracking
            // ****************
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    conn_q <= 1'b0;
                end else begin
                    conn_q <= pres_s;
                end
            end

            // ****************
            // speed latch
            // ****************
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    slow_q <= 1'b0;
                end else begin
                    // idle level decides speed; se0 carries none, so it is skipped
                    if (pres_s && !prst_q && !en_q && (dp_s || dm_s)) begin
                        slow_q <= dm_s & ~dp_s;
                    end else if (!pres_s) begin
                        slow_q <= 1'b0;
                    end
                end
            end

            // ****************
            // over-current edge capture
            // ****************
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    oc_prev_q <= 1'b0;
                    oc_flag_q <= 1'b0;
                end else begin
                    oc_prev_q <= oc_act;
                    // set wins over a clear in the same cycle
                    if (oc_rise) begin
                        oc_flag_q <= 1'b1;
                    end else if (wr_hit && io_wdata_i[BIT_OC_FLAG]) begin
                        oc_flag_q <= 1'b0;
                    end
                end
            end

            // ****************
            // port reset
            // ****************
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    prst_q <= 1'b0;
                end else if (wr_hit) begin
                    prst_q <= io_wdata_i[BIT_PRST];
                end
            end

            // ****************
            // enable: software sets, faults and reset clear
            // ****************
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    en_q <= 1'b0;
                end else if (prst_q || !pres_s || oc_rise) begin
                    en_q <= 1'b0;
                end else if (wr_hit && !(io_wdata_i[BIT_EN] && xact_busy_i[p])) begin
                    // a write setting enable while the bus is busy is ignored
                    en_q <= io_wdata_i[BIT_EN];
                end
            end

            // ****************
            // suspend request, deferred until the transaction ends
            // ****************
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    susp_q <= 1'b0;
                    susp_pend_q <= 1'b0;
                    sof_wait_q <= 1'b0;
                end else if (!en_q || prst_q) begin
                    susp_q <= 1'b0;
                    susp_pend_q <= 1'b0;
                    sof_wait_q <= 1'b0;
                end else if (wr_hit && !io_wdata_i[BIT_SUSP]) begin
                    susp_q <= 1'b0;
                    susp_pend_q <= 1'b0;
                    sof_wait_q <= 1'b0;
                end else if (wr_hit && io_wdata_i[BIT_SUSP] && !susp_q) begin
                    susp_pend_q <= 1'b1;
                    sof_wait_q <= babble_i[p];
                end else if (susp_pend_q && sof_wait_q) begin
                    if (sof_done_i[p]) begin
                        sof_wait_q <= 1'b0;
                    end
                end else if (susp_pend_q && !xact_busy_i[p]) begin
                    // bit flips only once blocking is really in place
                    susp_q <= 1'b1;
                    susp_pend_q <= 1'b0;
                end
            end

            // ****************
            // K-state on the line depends on speed
            // ****************
            assign k_line = slow_q ? (dp_s & ~dm_s) : (dm_s & ~dp_s);
            assign wake_set_hw = suspended && !wake_q && (kcnt_q == CNT_W'(RESUME_DET_CYC - 1));

            // ****************
            // resume detect timer
            // ****************
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    kcnt_q <= '0;
                end else if (!(suspended && k_line) || wake_q) begin
                    kcnt_q <= '0;
                end else if (kcnt_q != CNT_W'(RESUME_DET_CYC - 1)) begin
                    kcnt_q <= kcnt_q + CNT_W'(1);
                end
            end

            // ****************
            // wake bit: software or detection sets, clear ends with EOP
            // ****************
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    wake_q <= 1'b0;
                end else if (wake_set_hw) begin
                    wake_q <= 1'b1;
                end else if (wr_hit && io_wdata_i[BIT_WAKE] && !eop_busy) begin
                    wake_q <= 1'b1;
                end else if (eop_q == EOP_J && eop_cnt_q == '0) begin
                    wake_q <= 1'b0;
                end
            end

            // ****************
            // low-speed end-of-packet sequencer
            // ****************
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    eop_q <= EOP_IDLE;
                    eop_cnt_q <= '0;
                end else begin
                    case (eop_q)
                        EOP_IDLE: begin
                            if (wake_q && wr_hit && !io_wdata_i[BIT_WAKE]) begin
                                eop_q <= EOP_SE0;
                                eop_cnt_q <= CNT_W'(EOP_SE0_CYC - 1);
                            end
                        end
                        EOP_SE0: begin
                            if (eop_cnt_q == '0) begin
                                eop_q <= EOP_J;
                                eop_cnt_q <= CNT_W'(EOP_J_CYC - 1);
                            end else begin
                                eop_cnt_q <= eop_cnt_q - CNT_W'(1);
                            end
                        end
                        EOP_J: begin
                            if (eop_cnt_q == '0) begin
                                eop_q <= EOP_IDLE;
                            end else begin
                                eop_cnt_q <= eop_cnt_q - CNT_W'(1);
                            end
                        end
                        default: begin
                            eop_q <= EOP_IDLE;
                            eop_cnt_q <= '0;
                        end
                    endcase
                end
            end

            // ****************
            // registered line drive
            // ****************
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    drive_se0_o[p] <= 1'b0;
                    drive_k_o[p] <= 1'b0;
                    drive_j_o[p] <= 1'b0;
                end else begin
                    // reset signaling passes even while suspended
                    drive_se0_o[p] <= prst_q || (eop_q == EOP_SE0);
                    // K only while suspended, so a stray wake write stays quiet
                    drive_k_o[p] <= wake_q && suspended && !eop_busy;
                    drive_j_o[p] <= (eop_q == EOP_J);
                end
            end

            // ****************
            // registered port state
            // ****************
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    traffic_block_o[p] <= 1'b0;
                    sof_req_o[p] <= 1'b0;
                    port_en_o[p] <= 1'b0;
                end else begin
                    traffic_block_o[p] <= suspended && !prst_q;
                    sof_req_o[p] <= susp_pend_q && sof_wait_q;
                    port_en_o[p] <= en_q && !susp_q;
                end
            end

            // ****************
            // readback word
            // ****************
            always_comb begin
                reg_val[p] = 16'h0000;
                reg_val[p][BIT_SUSP] = susp_q;
                reg_val[p][BIT_OC_FLAG] = oc_flag_q;
                reg_val[p][BIT_OC_ACT] = oc_act;
                reg_val[p][BIT_PRST] = prst_q;
                reg_val[p][BIT_SLOW] = slow_q;
                reg_val[p][BIT_RSV_ONE] = PORT_STATUS_CONTROL_RESET[BIT_RSV_ONE];
                reg_val[p][BIT_WAKE] = wake_q;
                reg_val[p][BIT_LINE_DM] = dm_s;
                reg_val[p][BIT_LINE_DP] = dp_s;
                reg_val[p][BIT_EN] = en_q;
                reg_val[p][BIT_CONN] = conn_q;
            end
        end
    endgenerate

    // ***************************************************
    // read data
    // ***************************************************
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io_rdata_o <= 16'h0000;
        end else if (io_rd_i) begin
            io_rdata_o <= 16'h0000;
            for (int i = 0; i < NPORTS; i++) begin
                if (port_hit(io_addr_i, i)) begin
                    io_rdata_o <= reg_val[i];
                end
            end
        end
    end

endmodule

/* File: test/usb_device_model.sv */
// behavioural usb device standing on one downstream port
`timescale 1ns/1ps
module usb_device_model (
    input wire logic attach_i,
    input wire logic slow_i,
    input wire logic wake_i,
    input wire logic host_se0_i,
    input wire logic host_k_i,
    input wire logic host_j_i,
    output logic present_o,
    output logic dp_o,
    output logic dm_o
);
    logic k_line;
    // detached lines sit at the host pull-downs, i.e. se0
    always_comb begin
        present_o = attach_i;
        k_line = (host_k_i || wake_i) && !host_j_i;
        if (!attach_i || host_se0_i) begin
            dp_o = 1'b0;
            dm_o = 1'b0;
        end else begin
            dp_o = k_line ^ ~slow_i;
            dm_o = ~dp_o;
        end
    end
endmodule

/* File: test/usb_root_port_status_control_properties.sv */
// assertion checker for the root port status/control pair
`timescale 1ns/1ps
module usb_root_port_status_control_properties
    import usb_port_pkg::*;
#(
    parameter int NPORTS = 2,
    parameter int FUNC_NUM = 0
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [1:0] io_be_i,
    input wire logic [15:0] io_wdata_i,
    input wire logic [15:0] io_rdata_o,
    input wire logic [NPORTS-1:0] xact_busy_i,
    input wire logic [NPORTS-1:0] sof_req_o,
    input wire logic [NPORTS-1:0] port_en_o,
    input wire logic [NPORTS-1:0] traffic_block_o,
    input wire logic [NPORTS-1:0] drive_se0_o,
    input wire logic [NPORTS-1:0] drive_k_o,
    input wire logic [NPORTS-1:0] drive_j_o,
    input wire logic [2:0] first_port_o
);
    // ****************
    // run lengths on port a, too long for a repetition
    // ****************
    int se0_run_q;
    int j_run_q;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            se0_run_q <= 0;
            j_run_q <= 0;
        end else begin
            se0_run_q <= drive_se0_o[0] ? se0_run_q + 1 : 0;
            j_run_q <= drive_j_o[0] ? j_run_q + 1 : 0;
        end
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_state_code: assert property ((port_en_o & traffic_block_o) == '0)
        else $error("port enabled and suspended at once");
    a_block_waits: assert property ($rose(traffic_block_o[0]) |->
        !$past(xact_busy_i[0]) || !$past(xact_busy_i[0], 2))
        else $error("blocking began during a transaction");
    a_sof_first: assert property ((sof_req_o & traffic_block_o) == '0)
        else $error("blocked while start of frame pending");
    a_reset_drive: assert property (io_wr_i && io_be_i == 2'b11
        && io_addr_i == PORT_A_OFS && io_wdata_i[9] |-> ##[1:3] drive_se0_o[0] && !port_en_o[0])
        else $error("port reset gave no reset signaling");
    a_read_fixed: assert property (io_rd_i
        && (io_addr_i == PORT_A_OFS || io_addr_i == PORT_B_OFS)
        |-> ##1 io_rdata_o[7] && io_rdata_o[15:13] == 3'h0)
        else $error("fixed bits read wrong");
    a_k_suspended: assert property (drive_k_o[0] |->
        traffic_block_o[0] || $past(traffic_block_o[0]))
        else $error("k driven on a port not suspended");
    a_eop_se0: assert property ($rose(drive_j_o[0]) |-> se0_run_q == EOP_SE0_CYC)
        else $error("eop se0 length wrong");
    a_eop_j: assert property ($fell(drive_j_o[0]) |-> j_run_q == EOP_J_CYC)
        else $error("eop j length wrong");
    a_k_j_apart: assert property ((drive_k_o & drive_j_o) == '0)
        else $error("k and j driven together");
    a_en_cause: assert property ($rose(port_en_o[0]) |-> $past(traffic_block_o[0])
        || $past(traffic_block_o[0], 2) || ($past(io_wr_i, 2)
        && $past(io_addr_i, 2) == PORT_A_OFS && $past(io_wdata_i[2], 2)))
        else $error("enable rose without software");
    a_first_port: assert property (first_port_o == 3'(FUNC_NUM * 2))
        else $error("first port number wrong");
endmodule

/* File: test/usb_root_port_status_control_test.sv */
// self-checking bench for the root port status/control pair
`timescale 1ns/1ps
module usb_root_port_status_control_test;
    import usb_port_pkg::*;
    logic mclk, rst_n, wr_stb, rd_stb;
    logic [7:0] addr;
    logic [1:0] be, oc_n, dp, dm, present, busy, babble, sof_done, sof_req, en, blk;
    logic [1:0] se0, drv_k, drv_j, attach, slow, wake;
    logic [15:0] wdata, rdata;
    logic [2:0] first_port;
    int errors = 0;
    int tests_run = 0;
    usb_root_port_status_control dut (.mclk_i(mclk), .rst_n_i(rst_n), .io_addr_i(addr),
        .io_wr_i(wr_stb), .io_rd_i(rd_stb), .io_be_i(be), .io_wdata_i(wdata),
        .io_rdata_o(rdata), .oc_n_i(oc_n), .line_dp_i(dp), .line_dm_i(dm),
        .dev_present_i(present), .xact_busy_i(busy), .babble_i(babble),
        .sof_done_i(sof_done), .sof_req_o(sof_req), .port_en_o(en),
        .traffic_block_o(blk), .drive_se0_o(se0), .drive_k_o(drv_k), .drive_j_o(drv_j),
        .first_port_o(first_port));
    for (genvar g = 0; g < 2; g++) begin : gen_dev
        usb_device_model dev (.attach_i(attach[g]), .slow_i(slow[g]), .wake_i(wake[g]),
            .host_se0_i(se0[g]), .host_k_i(drv_k[g]), .host_j_i(drv_j[g]),
            .present_o(present[g]), .dp_o(dp[g]), .dm_o(dm[g]));
    end
    // ****************
    // access tasks
    // ****************
    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b = 2'b11);
        @(negedge mclk);
        addr = a; be = b; wdata = d; wr_stb = 1'b1;
        @(negedge mclk);
        wr_stb = 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge mclk);
        addr = a; rd_stb = 1'b1;
        @(negedge mclk);
        rd_stb = 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        logic [15:0] d;
        bus_rd(a, d);
        chk($sformatf("reg %h", a), e, d & m);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic eop_wait(input int skip);
        logic [15:0] d;
        int n;
        n = 0;
        d = 16'h0040;
        while (d[6] !== 1'b0 && n < 200) begin
            bus_rd(8'h10, d);
            n++;
        end
        if (n == 200) begin
            errors++;
            conclude();
        end
        chk("eop polls", 16'h0001, {15'h0, n >= (EOP_SE0_CYC + EOP_J_CYC - skip) / 3});
    endtask
    task automatic conclude();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (100000) @(posedge mclk);
        errors++;
        conclude();
    end
    initial begin
        rst_n = 0; wr_stb = 0; rd_stb = 0; addr = '0; be = 2'b11; wdata = '0;
        oc_n = 2'b11; busy = '0; babble = '0; sof_done = '0; attach = '0; slow = '0; wake = '0;
        cyc(12);
        rst_n = 1;
        cyc(4);
        rchk(8'h10, 16'h0080, 16'hffff);
        rchk(8'h12, 16'h0080, 16'hffff);
        chk("first port", 16'h0000, {13'h0, first_port});
        rchk(8'h14, 16'h0000, 16'hffff);
        bus_wr(8'h10, 16'hffff, 2'b01);
        rchk(8'h10, 16'h0080, 16'hffff);
        bus_wr(8'h10, 16'he100);
        rchk(8'h10, 16'h0080, 16'hffff);
        attach = 2'b11; slow = 2'b01;
        cyc(8);
        rchk(8'h10, 16'h01a1, 16'hffff);
        rchk(8'h12, 16'h0091, 16'hffff);
        bus_wr(8'h10, 16'h0200);
        cyc(2);
        chk("se0", 16'h0001, {15'h0, se0[0]});
        rchk(8'h10, 16'h0200, 16'h0204);
        bus_wr(8'h10, 16'h0000);
        bus_wr(8'h10, 16'h0004);
        cyc(2);
        chk("enable", 16'h0001, {15'h0, en[0]});
        busy[0] = 1;
        bus_wr(8'h10, 16'h1004);
        cyc(6);
        chk("block", 16'h0000, {15'h0, blk[0]});
        rchk(8'h10, 16'h0004, 16'h1004);
        busy[0] = 0;
        cyc(3);
        chk("block", 16'h0001, {15'h0, blk[0]});
        chk("enable", 16'h0000, {15'h0, en[0]});
        rchk(8'h10, 16'h1004, 16'h1004);
        wake[0] = 1;
        cyc(3000);
        rchk(8'h10, 16'h0000, 16'h0040);
        cyc(300);
        rchk(8'h10, 16'h0040, 16'h0040);
        wake[0] = 0;
        cyc(2);
        chk("k", 16'h0001, {15'h0, drv_k[0]});
        bus_wr(8'h10, 16'h1004);
        cyc(50);
        chk("se0", 16'h0001, {15'h0, se0[0]});
        eop_wait(50);
        bus_wr(8'h10, 16'h1044);
        cyc(3);
        chk("k", 16'h0001, {15'h0, drv_k[0]});
        bus_wr(8'h10, 16'h1004);
        eop_wait(0);
        bus_wr(8'h10, 16'h0004);
        cyc(2);
        chk("enable", 16'h0001, {15'h0, en[0]});
        bus_wr(8'h12, 16'h0004);
        oc_n[1] = 0;
        cyc(6);
        chk("enable", 16'h0000, {15'h0, en[1]});
        rchk(8'h12, 16'h0c00, 16'h0c04);
        oc_n[1] = 1;
        cyc(4);
        rchk(8'h12, 16'h0800, 16'h0c00);
        bus_wr(8'h12, 16'h0800);
        rchk(8'h12, 16'h0000, 16'h0800);
        bus_wr(8'h12, 16'h0004);
        babble[1] = 1;
        bus_wr(8'h12, 16'h1004);
        babble[1] = 0;
        cyc(3);
        chk("sof request", 16'h0001, {15'h0, sof_req[1]});
        chk("block", 16'h0000, {15'h0, blk[1]});
        sof_done[1] = 1;
        cyc(1);
        sof_done[1] = 0;
        cyc(3);
        chk("block", 16'h0001, {15'h0, blk[1]});
        conclude();
    end
endmodule
bind usb_root_port_status_control usb_root_port_status_control_properties #(
    .NPORTS(NPORTS), .FUNC_NUM(FUNC_NUM)) props (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_be_i(io_be_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .xact_busy_i(xact_busy_i),
    .sof_req_o(sof_req_o), .port_en_o(port_en_o), .traffic_block_o(traffic_block_o),
    .drive_se0_o(drive_se0_o), .drive_k_o(drive_k_o), .drive_j_o(drive_j_o),
    .first_port_o(first_port_o));
